/* File: common/dio_card_pkg.sv */
package dio_card_pkg;
	localparam int unsigned NUM_PORTS       = 21;
	localparam int unsigned NUM_PORTS_SHORT = 18;
	localparam int unsigned PORT_W          = 8;
	localparam int unsigned SEL_W           = 5;
	localparam int unsigned ADDR_W          = 8;
	localparam int unsigned DATA_W          = 8;
	localparam int unsigned SIDE_W          = 8;
	localparam int unsigned IRQ_W           = 4;
	localparam int unsigned CODE_W          = 4;
	localparam int unsigned BOARD_NUM_W     = 4;
	localparam int unsigned DIR_GROUP_W     = 6;
	localparam int unsigned DIR_LAST_W      = 3;
	localparam int unsigned GLOBAL_EN_BIT   = 0;
	localparam int unsigned STATUS_CODE_LSB = 4;

	// io_base_offset relative byte offsets
	localparam logic [ADDR_W-1:0] OFF_GLOBAL_EN   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SIDE_DIR    = 8'h02;
	localparam logic [ADDR_W-1:0] OFF_SIDE_DATA   = 8'h03;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK    = 8'h05;
	localparam logic [ADDR_W-1:0] OFF_SIDE_STATUS = 8'h07;
	localparam logic [ADDR_W-1:0] OFF_IRQ_POL     = 8'h2a;
	localparam logic [ADDR_W-1:0] OFF_WINDOW      = 8'hc0;
	localparam logic [ADDR_W-1:0] OFF_PORT_SEL    = 8'hc4;
	localparam logic [ADDR_W-1:0] OFF_DIR_0_5     = 8'hc8;
	localparam logic [ADDR_W-1:0] OFF_DIR_6_11    = 8'hcc;
	localparam logic [ADDR_W-1:0] OFF_DIR_12_17   = 8'hd0;
	localparam logic [ADDR_W-1:0] OFF_DIR_18_20   = 8'hd4;
	localparam logic [ADDR_W-1:0] OFF_BOARD_NUM   = 8'hf0;

	localparam logic [SEL_W-1:0] LAST_PORT_WIDE  = 5'h14;
	localparam logic [SEL_W-1:0] LAST_PORT_SHORT = 5'h11;

	localparam logic               RST_GLOBAL_EN = 1'b0;
	localparam logic [SIDE_W-1:0]  RST_SIDE_DIR  = 8'h00;
	localparam logic [SIDE_W-1:0]  RST_SIDE_DATA = 8'h00;
	localparam logic [IRQ_W-1:0]   RST_IRQ_MASK  = 4'h0;
	localparam logic [IRQ_W-1:0]   RST_IRQ_POL   = 4'hf;
	localparam logic [SEL_W-1:0]   RST_PORT_SEL  = 5'h00;
	localparam logic [NUM_PORTS-1:0] RST_PORT_DIR = 21'h1fffff;
	localparam logic [PORT_W-1:0]  RST_OUT_LATCH = 8'h00;
	localparam logic [DATA_W-1:0]  READ_RESERVED = 8'h00;
endpackage : dio_card_pkg

/* File: common/port_bank_if.sv */
`timescale 1ns/1ps
interface port_bank_if;
	import dio_card_pkg::*;
	logic                        enable;
	logic                        wr;
	logic                        rd;
	logic                        sel_ok;
	logic [SEL_W-1:0]            sel;
	logic [PORT_W-1:0]           wdata;
	logic [NUM_PORTS-1:0]        dir_in;
	logic [PORT_W-1:0]           rd_data;

	modport ctrl (
		output enable,
		output wr,
		output rd,
		output sel_ok,
		output sel,
		output wdata,
		output dir_in,
		input  rd_data
	);
	modport bank (
		input  enable,
		input  wr,
		input  rd,
		input  sel_ok,
		input  sel,
		input  wdata,
		input  dir_in,
		output rd_data
	);
endinterface : port_bank_if

/* File: hw/window_bank.sv */
`timescale 1ns/1ps
module window_bank
	import dio_card_pkg::*;
(
	input  wire logic                          sys_clk_i,
	input  wire logic                          rst_ni,
	port_bank_if.bank                          bus,
	input  wire logic [NUM_PORTS*PORT_W-1:0]   port_in_i,
	output logic      [NUM_PORTS*PORT_W-1:0]   port_out_o,
	output logic      [NUM_PORTS*PORT_W-1:0]   port_oe_n_o
);
	import dio_card_pkg::*;

	logic [PORT_W-1:0] latch_q [NUM_PORTS];
	logic [PORT_W-1:0] rd_data_q;
	logic [PORT_W-1:0] rd_data_d;

	always_ff @(posedge sys_clk_i or negedge rst_ni)
	begin
		if (!rst_ni)
		begin
			for (int i = 0; i < NUM_PORTS; i++)
				latch_q[i] <= RST_OUT_LATCH;
		end
		else if (bus.wr && bus.enable && bus.sel_ok)
		begin
			latch_q[bus.sel] <= bus.wdata;
		end
	end

	always_comb
	begin
		rd_data_d = READ_RESERVED;
		if (bus.enable && bus.sel_ok)
		begin
			if (bus.dir_in[bus.sel])
				rd_data_d = port_in_i[bus.sel*PORT_W +: PORT_W];
			else
				rd_data_d = latch_q[bus.sel];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_ni)
	begin
		if (!rst_ni)
			rd_data_q <= READ_RESERVED;
		else if (bus.rd)
			rd_data_q <= rd_data_d;
	end

	assign bus.rd_data = rd_data_q;

	always_comb
	begin
		for (int i = 0; i < NUM_PORTS; i++)
		begin
			port_out_o[i*PORT_W +: PORT_W]  = latch_q[i];
			port_oe_n_o[i*PORT_W +: PORT_W] = {PORT_W{bus.dir_in[i] | ~bus.enable}};
		end
	end
endmodule : window_bank

/* File: hw/dio_card_top.sv */
`timescale 1ns/1ps
module dio_card_top
	import dio_card_pkg::*;
#(
	parameter bit WIDE_VARIANT = 1'b1
)
(
	input  wire logic                          sys_clk_i,
	input  wire logic                          nrst_i,
	input  wire logic [ADDR_W-1:0]             io_addr_i,
	input  wire logic                          io_wr_i,
	input  wire logic                          io_rd_i,
	input  wire logic [DATA_W-1:0]             io_wdata_i,
	output logic      [DATA_W-1:0]             io_rdata_o,
	output logic                               io_rvalid_o,
	input  wire logic [NUM_PORTS*PORT_W-1:0]   port_in_i,
	output logic      [NUM_PORTS*PORT_W-1:0]   port_out_o,
	output logic      [NUM_PORTS*PORT_W-1:0]   port_oe_n_o,
	input  wire logic [SIDE_W-1:0]             side_line_bit_i,
	output logic      [SIDE_W-1:0]             side_line_bit_o,
	output logic      [SIDE_W-1:0]             side_line_bit_oe_n_o,
	input  wire logic [IRQ_W-1:0]              irq_input_line_i,
	input  wire logic [CODE_W-1:0]             daughter_board_code_i,
	input  wire logic [BOARD_NUM_W-1:0]        board_number_i,
	output logic                               irq_o
);
	import dio_card_pkg::*;

	logic                  rst_meta_q;
	logic                  rst_sync_q;
	logic                  rst_n;

	logic                  global_io_enable_q;
	logic [SIDE_W-1:0]     side_line_direction_q;
	logic [SIDE_W-1:0]     side_line_data_q;
	logic [IRQ_W-1:0]      interrupt_enable_mask_q;
	logic [IRQ_W-1:0]      interrupt_polarity_q;
	logic [SEL_W-1:0]      active_port_select_q;
	logic [NUM_PORTS-1:0]  port_dir_q;
	logic [IRQ_W-1:0]      irq_adjusted;
	logic                  irq_q;
	logic                  sel_ok;

	logic [NUM_PORTS_SHORT-1:0] port_dir_lo_q;
	logic [DIR_LAST_W-1:0]      port_dir_hi_q;
	logic [DATA_W-1:0]          status_word;
	logic [DATA_W-1:0]          board_word;

	logic [DATA_W-1:0]     rdata_q;
	logic [DATA_W-1:0]     rdata_d;
	logic                  rvalid_q;
	logic                  win_rd_q;

	logic                  wr_global;
	logic                  wr_side_dir;
	logic                  wr_side_data;
	logic                  wr_mask;
	logic                  wr_pol;
	logic                  wr_window;
	logic                  wr_sel;
	logic                  wr_dir0;
	logic                  wr_dir1;
	logic                  wr_dir2;
	logic                  wr_dir3;
	logic                  rd_window;

	port_bank_if bank_bus ();

	// reset released through two flops, asserted at once
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign rst_n = rst_sync_q;

	// exact compare: a partial decode would alias reserved offsets onto live registers
	// only mapped offsets decode writes
	assign wr_global    = io_wr_i && (io_addr_i == OFF_GLOBAL_EN);
	assign wr_side_dir  = io_wr_i && (io_addr_i == OFF_SIDE_DIR);
	assign wr_side_data = io_wr_i && (io_addr_i == OFF_SIDE_DATA);
	assign wr_mask      = io_wr_i && (io_addr_i == OFF_IRQ_MASK);
	assign wr_pol       = io_wr_i && (io_addr_i == OFF_IRQ_POL);
	assign wr_window    = io_wr_i && (io_addr_i == OFF_WINDOW);
	assign wr_sel       = io_wr_i && (io_addr_i == OFF_PORT_SEL);
	assign wr_dir0      = io_wr_i && (io_addr_i == OFF_DIR_0_5);
	assign wr_dir1      = io_wr_i && (io_addr_i == OFF_DIR_6_11);
	assign wr_dir2      = io_wr_i && (io_addr_i == OFF_DIR_12_17);
	assign wr_dir3      = io_wr_i && (io_addr_i == OFF_DIR_18_20);
	assign rd_window    = io_rd_i && (io_addr_i == OFF_WINDOW);

	// side lines and interrupts ignore this bit; only the port bank is gated
	// global enable bit
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			global_io_enable_q <= RST_GLOBAL_EN;
		else if (wr_global)
			global_io_enable_q <= io_wdata_i[GLOBAL_EN_BIT];
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			side_line_direction_q <= RST_SIDE_DIR;
		else if (wr_side_dir)
			side_line_direction_q <= io_wdata_i;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			side_line_data_q <= RST_SIDE_DATA;
		else if (wr_side_data)
			side_line_data_q <= io_wdata_i;
	end

	assign side_line_bit_o      = side_line_data_q;
	assign side_line_bit_oe_n_o = ~side_line_direction_q;

	// upper mask bits are dropped; only four lines exist
	// interrupt source mask
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			interrupt_enable_mask_q <= RST_IRQ_MASK;
		else if (wr_mask)
			interrupt_enable_mask_q <= io_wdata_i[IRQ_W-1:0];
	end

	// reset passes every line straight through
	// polarity select
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			interrupt_polarity_q <= RST_IRQ_POL;
		else if (wr_pol)
			interrupt_polarity_q <= io_wdata_i[IRQ_W-1:0];
	end

	assign irq_adjusted = ~(irq_input_line_i ^ interrupt_polarity_q);

	// registered so a decode glitch never reaches the host as a runt pulse
	// level request, registered one cycle
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			irq_q <= 1'b0;
		else
			irq_q <= |(irq_adjusted & interrupt_enable_mask_q);
	end

	assign irq_o = irq_q;

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			active_port_select_q <= RST_PORT_SEL;
		else if (wr_sel)
			active_port_select_q <= io_wdata_i[SEL_W-1:0];
	end

	// a wild select number must never index past the bank
	// port count follows variant
	assign sel_ok = WIDE_VARIANT ? (active_port_select_q <= LAST_PORT_WIDE)
	                             : (active_port_select_q <= LAST_PORT_SHORT);

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			port_dir_lo_q <= RST_PORT_DIR[NUM_PORTS_SHORT-1:0];
		else
		begin
			if (wr_dir0)
				port_dir_lo_q[0 +: DIR_GROUP_W] <= io_wdata_i[DIR_GROUP_W-1:0];
			if (wr_dir1)
				port_dir_lo_q[DIR_GROUP_W +: DIR_GROUP_W] <= io_wdata_i[DIR_GROUP_W-1:0];
			if (wr_dir2)
				port_dir_lo_q[2*DIR_GROUP_W +: DIR_GROUP_W] <= io_wdata_i[DIR_GROUP_W-1:0];
		end
	end

	// last group only on wide variant
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			port_dir_hi_q <= RST_PORT_DIR[NUM_PORTS-1:NUM_PORTS_SHORT];
		else if (wr_dir3 && WIDE_VARIANT)
			port_dir_hi_q <= io_wdata_i[DIR_LAST_W-1:0];
	end

	// two flops keep one writer each; the bank sees one flat word
	assign port_dir_q = {port_dir_hi_q, port_dir_lo_q};

	// the bank sees the window only through these strobes
	assign bank_bus.enable = global_io_enable_q;
	assign bank_bus.wr     = wr_window;
	assign bank_bus.rd     = rd_window;
	assign bank_bus.sel_ok = sel_ok;
	assign bank_bus.sel    = active_port_select_q;
	assign bank_bus.wdata  = io_wdata_i;
	assign bank_bus.dir_in = port_dir_q;

	window_bank u_bank (
		.sys_clk_i   (sys_clk_i),
		.rst_ni      (rst_n),
		.bus         (bank_bus),
		.port_in_i   (port_in_i),
		.port_out_o  (port_out_o),
		.port_oe_n_o (port_oe_n_o)
	);

	assign status_word = {daughter_board_code_i, irq_input_line_i};
	assign board_word  = {{(DATA_W-BOARD_NUM_W){1'b0}}, board_number_i};

	always_comb
	begin
		rdata_d = READ_RESERVED;
		unique case (io_addr_i)
			OFF_SIDE_DATA:
				rdata_d = side_line_data_q;
			OFF_SIDE_STATUS:
				rdata_d = status_word;
			OFF_BOARD_NUM:
				rdata_d = board_word;
			// window data comes from the bank's own flop
			OFF_WINDOW:
				rdata_d = READ_RESERVED;
			default:
				rdata_d = READ_RESERVED;
		endcase
	end

	// read answer one edge after the strobe
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			rvalid_q <= 1'b0;
		else
			rvalid_q <= io_rd_i;
	end

	// source choice kept with the data so the answer stands until the next read
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			win_rd_q <= 1'b0;
		else if (io_rd_i)
			win_rd_q <= rd_window;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= READ_RESERVED;
		else if (io_rd_i)
			rdata_q <= rdata_d;
	end

	// window data already sits in the bank's own flop; mux only picks a source
	assign io_rdata_o  = win_rd_q ? bank_bus.rd_data : rdata_q;
	assign io_rvalid_o = rvalid_q;
endmodule : dio_card_top

/* File: tb/dio_card_properties.sv */
`timescale 1ns/1ps
module dio_card_properties
	import dio_card_pkg::*;
#(
	parameter bit WIDE_VARIANT = 1'b1
)
(
	input wire logic                        sys_clk_i,
	input wire logic                        nrst_i,
	input wire logic [ADDR_W-1:0]           io_addr_i,
	input wire logic                        io_wr_i,
	input wire logic                        io_rd_i,
	input wire logic [DATA_W-1:0]           io_wdata_i,
	input wire logic [DATA_W-1:0]           io_rdata_o,
	input wire logic                        io_rvalid_o,
	input wire logic [NUM_PORTS*PORT_W-1:0] port_in_i,
	input wire logic [NUM_PORTS*PORT_W-1:0] port_out_o,
	input wire logic [NUM_PORTS*PORT_W-1:0] port_oe_n_o,
	input wire logic [SIDE_W-1:0]           side_line_bit_o,
	input wire logic [SIDE_W-1:0]           side_line_bit_oe_n_o,
	input wire logic [IRQ_W-1:0]            irq_input_line_i,
	input wire logic [CODE_W-1:0]           daughter_board_code_i,
	input wire logic                        irq_o
);
	logic                        en_q, sel_ok, irq_calc, rd_map, rd_win, rd_stat, wr_win;
	logic [SIDE_W-1:0]           sd_q, so_q;
	logic [IRQ_W-1:0]            msk_q, pol_q;
	logic [SEL_W-1:0]            sel_q;
	logic [NUM_PORTS-1:0]        dir_q;
	logic [NUM_PORTS*PORT_W-1:0] oe_n;
	logic [PORT_W-1:0]           win;

	// shadow of the written registers, since all of them but the side data register are write-only
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			en_q  <= 1'b0;
			sd_q  <= '0;
			so_q  <= RST_SIDE_DATA;
			msk_q <= '0;
			pol_q <= RST_IRQ_POL;
			sel_q <= RST_PORT_SEL;
			dir_q <= '1;
		end
		else if (io_wr_i)
		begin
			case (io_addr_i)
				OFF_GLOBAL_EN: en_q <= io_wdata_i[0];
				OFF_SIDE_DIR:  sd_q <= io_wdata_i;
				OFF_SIDE_DATA: so_q <= io_wdata_i;
				OFF_IRQ_MASK:  msk_q <= io_wdata_i[3:0];
				OFF_IRQ_POL:   pol_q <= io_wdata_i[3:0];
				OFF_PORT_SEL:  sel_q <= io_wdata_i[4:0];
				OFF_DIR_0_5:   dir_q[5:0] <= io_wdata_i[5:0];
				OFF_DIR_6_11:  dir_q[11:6] <= io_wdata_i[5:0];
				OFF_DIR_12_17: dir_q[17:12] <= io_wdata_i[5:0];
				OFF_DIR_18_20: if (WIDE_VARIANT) dir_q[20:18] <= io_wdata_i[2:0];
				default: ;
			endcase
		end
	end

	always_comb
	begin
		sel_ok   = en_q && (sel_q <= (WIDE_VARIANT ? LAST_PORT_WIDE : LAST_PORT_SHORT));
		win      = READ_RESERVED;
		if (sel_ok)
			win = dir_q[sel_q] ? port_in_i[sel_q*PORT_W +: PORT_W] : port_out_o[sel_q*PORT_W +: PORT_W];
		for (int n = 0; n < NUM_PORTS; n++)
			oe_n[n*PORT_W +: PORT_W] = {PORT_W{!(en_q && !dir_q[n])}};
		irq_calc = |(msk_q & ~(irq_input_line_i ^ pol_q));
		rd_map   = io_addr_i inside {OFF_SIDE_DATA, OFF_SIDE_STATUS, OFF_WINDOW, OFF_BOARD_NUM};
		rd_win   = io_rd_i && (io_addr_i == OFF_WINDOW);
		rd_stat  = io_rd_i && (io_addr_i == OFF_SIDE_STATUS);
		wr_win   = io_wr_i && (io_addr_i == OFF_WINDOW);
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);

	rvalid_pulse_a: assert property (io_rvalid_o == $past(io_rd_i))
		else $error("read valid not one cycle after its strobe");
	reserved_read_a: assert property (io_rd_i && !rd_map |=> io_rdata_o == READ_RESERVED)
		else $error("reserved read not zero");
	status_read_a: assert property (rd_stat |=> io_rdata_o == $past({daughter_board_code_i, irq_input_line_i}))
		else $error("status read wrong");
	side_dir_a: assert property (side_line_bit_oe_n_o == ~sd_q)
		else $error("side line drive enable wrong");
	side_data_a: assert property (side_line_bit_o == so_q)
		else $error("side line level wrong");
	irq_level_a: assert property (irq_o == $past(irq_calc))
		else $error("interrupt request wrong");
	port_drive_a: assert property (port_oe_n_o == oe_n)
		else $error("port drive enable wrong");
	window_write_a: assert property (wr_win && sel_ok |=> port_out_o[sel_q*PORT_W +: PORT_W] == $past(io_wdata_i))
		else $error("window write not on active port");
	window_hold_a: assert property (wr_win && !en_q |=> $stable(port_out_o))
		else $error("window write while disabled");
	window_read_a: assert property (rd_win |=> io_rdata_o == $past(win))
		else $error("window read wrong");
endmodule : dio_card_properties

bind dio_card_top dio_card_properties #(.WIDE_VARIANT(WIDE_VARIANT)) i_dio_card_properties (.sys_clk_i, .nrst_i,
	.io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o, .io_rvalid_o, .port_in_i, .port_out_o, .port_oe_n_o,
	.side_line_bit_o, .side_line_bit_oe_n_o, .irq_input_line_i, .daughter_board_code_i, .irq_o);

/* File: tb/field_io_model.sv */
`timescale 1ns/1ps
module field_io_model
	import dio_card_pkg::*;
(
	input  wire logic [NUM_PORTS*PORT_W-1:0] field_i,
	input  wire logic [NUM_PORTS*PORT_W-1:0] port_out_i,
	input  wire logic [NUM_PORTS*PORT_W-1:0] port_oe_n_i,
	input  wire logic [SIDE_W-1:0]           side_field_i,
	input  wire logic [SIDE_W-1:0]           side_out_i,
	input  wire logic [SIDE_W-1:0]           side_oe_n_i,
	output logic      [NUM_PORTS*PORT_W-1:0] port_in_o,
	output logic      [SIDE_W-1:0]           side_in_o
);
	// a driven pin reads back the card, a released one follows the field device
	assign port_in_o = (port_oe_n_i & field_i) | (~port_oe_n_i & port_out_i);
	assign side_in_o = (side_oe_n_i & side_field_i) | (~side_oe_n_i & side_out_i);
endmodule : field_io_model

/* File: tb/banked_parallel_io_card_bench.sv */
`timescale 1ns/1ps
module banked_parallel_io_card_bench;
	import dio_card_pkg::*;
	logic                        sys_clk_i = 1'b0, nrst_i = 1'b0, io_wr_i = 1'b0, io_rd_i = 1'b0;
	logic [ADDR_W-1:0]           io_addr_i = '0;
	logic [DATA_W-1:0]           io_wdata_i = '0;
	logic [DATA_W-1:0]           io_rdata_o, d, s_rdata;
	logic                        io_rvalid_o, irq_o, en;
	logic [NUM_PORTS*PORT_W-1:0] port_in_i, port_out_o, port_oe_n_o;
	logic [NUM_PORTS*PORT_W-1:0] field = '0;
	logic [SIDE_W-1:0]           side_line_bit_i, side_line_bit_o, side_line_bit_oe_n_o, sd, so;
	logic [IRQ_W-1:0]            irq_input_line_i = '0;
	logic [CODE_W-1:0]           daughter_board_code_i = '0;
	logic [BOARD_NUM_W-1:0]      board_number_i = '0;
	logic [NUM_PORTS-1:0]        dir;
	logic [SEL_W-1:0]            sel;
	logic [PORT_W-1:0]           outl [NUM_PORTS];
	logic [IRQ_W-1:0]            msk, pol;
	logic [7:0]                  rsv [7] = '{8'h00, 8'h02, 8'h05, 8'h2a, 8'hc4, 8'hd4, 8'h10};
	logic [7:0]                  sels [4] = '{8'd0, 8'd20, 8'd21, 8'd19};
	int                          op, g, err_total = 0, total_checks = 0;

	dio_card_top #(.WIDE_VARIANT(1'b1)) i_dio_card_top (.sys_clk_i, .nrst_i, .io_addr_i, .io_wr_i, .io_rd_i,
		.io_wdata_i, .io_rdata_o, .io_rvalid_o, .port_in_i, .port_out_o, .port_oe_n_o, .side_line_bit_i,
		.side_line_bit_o, .side_line_bit_oe_n_o, .irq_input_line_i, .daughter_board_code_i, .board_number_i, .irq_o);
	field_io_model i_field_io_model (.field_i(field), .port_out_i(port_out_o), .port_oe_n_i(port_oe_n_o),
		.side_field_i(~field[SIDE_W-1:0]), .side_out_i(side_line_bit_o), .side_oe_n_i(side_line_bit_oe_n_o),
		.port_in_o(port_in_i), .side_in_o(side_line_bit_i));
	dio_card_top #(.WIDE_VARIANT(1'b0)) i_dio_card_top_short (.sys_clk_i, .nrst_i, .io_addr_i, .io_wr_i, .io_rd_i,
		.io_wdata_i, .io_rdata_o(s_rdata), .io_rvalid_o(), .port_in_i, .port_out_o(), .port_oe_n_o(),
		.side_line_bit_i, .side_line_bit_o(), .side_line_bit_oe_n_o(), .irq_input_line_i, .daughter_board_code_i,
		.board_number_i, .irq_o());

	always #2 sys_clk_i = ~sys_clk_i;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// strobe stays up so that the next call can follow back to back
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge sys_clk_i);
		io_rd_i = 1'b0;
		io_wr_i = 1'b1;
		io_addr_i = a;
		io_wdata_i = v;
		case (a)
			OFF_GLOBAL_EN: en = v[0];
			OFF_SIDE_DIR:  sd = v;
			OFF_SIDE_DATA: so = v;
			OFF_IRQ_MASK:  msk = v[3:0];
			OFF_IRQ_POL:   pol = v[3:0];
			OFF_PORT_SEL:  sel = v[4:0];
			OFF_DIR_0_5:   dir[5:0] = v[5:0];
			OFF_DIR_6_11:  dir[11:6] = v[5:0];
			OFF_DIR_12_17: dir[17:12] = v[5:0];
			OFF_DIR_18_20: dir[20:18] = v[2:0];
			OFF_WINDOW:    if (en && sel <= 5'd20) outl[sel] = v;
			default: ;
		endcase
	endtask : wr

	function automatic logic [7:0] exp_win();
		if (!en || sel > 5'd20)
			return 8'h00;
		return dir[sel] ? field[sel*PORT_W +: PORT_W] : outl[sel];
	endfunction : exp_win

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk_i);
		io_wr_i = 1'b0;
		io_rd_i = 1'b1;
		io_addr_i = a;
		@(negedge sys_clk_i);
		io_rd_i = 1'b0;
		chk({7'h0, io_rvalid_o}, 8'h01);
		chk(io_rdata_o, exp);
	endtask : rd

	task automatic settle();
		@(negedge sys_clk_i);
		io_wr_i = 1'b0;
		@(negedge sys_clk_i);
		for (int n = 0; n < NUM_PORTS; n++)
		begin
			chk(port_oe_n_o[n*PORT_W +: PORT_W], {8{!(en && !dir[n])}});
			chk(port_out_o[n*PORT_W +: PORT_W], outl[n]);
		end
		chk(side_line_bit_oe_n_o, ~sd);
		chk(side_line_bit_o, so);
		chk({7'h0, irq_o}, {7'h0, |(msk & ~(irq_input_line_i ^ pol))});
	endtask : settle

	task automatic chg();
		@(negedge sys_clk_i);
		io_wr_i = 1'b0;
		for (int n = 0; n < NUM_PORTS; n++)
			field[n*PORT_W +: PORT_W] = 8'($urandom);
		{irq_input_line_i, daughter_board_code_i, board_number_i} = 12'($urandom);
	endtask : chg

	task automatic do_reset();
		@(negedge sys_clk_i);
		io_wr_i = 1'b0;
		io_rd_i = 1'b0;
		nrst_i = 1'b0;
		{en, sel, msk, sd, so} = '0;
		dir = '1;
		pol = RST_IRQ_POL;
		foreach (outl[i]) outl[i] = 8'h00;
		repeat (5) @(negedge sys_clk_i);
		nrst_i = 1'b1;
		repeat (3) @(negedge sys_clk_i);
	endtask : do_reset

	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	initial
	begin
		void'($urandom(32'h102e57af));
		do_reset();
		chg();
		settle();
		foreach (rsv[i]) rd(rsv[i], READ_RESERVED);
		wr(OFF_SIDE_STATUS, 8'hff);
		wr(OFF_BOARD_NUM, 8'hff);
		// directions set before any window access
		for (int k = 0; k < 4; k++) wr(OFF_DIR_0_5 + 8'(4 * k), 8'h00);
		wr(OFF_WINDOW, 8'ha5);
		rd(OFF_WINDOW, exp_win());
		settle();
		wr(OFF_GLOBAL_EN, 8'h01);
		wr(OFF_DIR_18_20, 8'h03);
		foreach (sels[i])
		begin
			wr(OFF_PORT_SEL, sels[i]);
			wr(OFF_WINDOW, sels[i] ^ 8'h5a);
			rd(OFF_WINDOW, exp_win());
			chk(s_rdata, (sel <= LAST_PORT_SHORT) ? exp_win() : READ_RESERVED);
		end
		rd(OFF_BOARD_NUM, {4'h0, board_number_i});
		for (int k = 0; k < 16; k++)
		begin
			wr(OFF_IRQ_MASK, 8'(k));
			wr(OFF_IRQ_POL, 8'(15 - k));
			settle();
			if (irq_o === 1'b1)
				rd(OFF_SIDE_STATUS, {daughter_board_code_i, irq_input_line_i});
		end
		repeat (300)
		begin
			op = $urandom_range(9);
			d = 8'($urandom);
			g = $urandom_range(3);
			case (op)
				0: wr(OFF_DIR_0_5 + 8'(4 * g), d & ((g == 3) ? 8'h07 : 8'h3f));
				1: wr(OFF_PORT_SEL, 8'($urandom_range(23)));
				2: wr(OFF_WINDOW, d);
				3:
				begin
					rd(OFF_WINDOW, exp_win());
					chk(s_rdata, (sel <= LAST_PORT_SHORT) ? exp_win() : READ_RESERVED);
				end
				4: rd(OFF_SIDE_STATUS, {daughter_board_code_i, irq_input_line_i});
				5: wr(g[0] ? OFF_IRQ_MASK : OFF_IRQ_POL, d & 8'h0f);
				6: wr(OFF_SIDE_DIR + 8'(g[0]), d);
				7: rd(OFF_SIDE_DATA, so);
				8: wr(OFF_GLOBAL_EN, {7'h0, d[0] | d[1]});
				default: chg();
			endcase
			if (op > 4)
				settle();
		end
		do_reset();
		settle();
		rd(OFF_WINDOW, exp_win());
		end_sim();
	end

	initial
	begin
		#(20000 * 4);
		err_total++;
		end_sim();
	end
endmodule : banked_parallel_io_card_bench
